// >>> verilog/pdeo_pkg.sv
// constants for the port d/e alternate function override block
// assumes one system clock domain and 8-bit port registers
package pdeo_pkg;
    localparam int PDEO_PORT_W = 8;
    localparam int PDEO_PM_W = 4;
    // port d lcd hand-over thresholds, by pin pair
    localparam logic [3:0] PDEO_PM_THR_76 = 4'h1;
    localparam logic [3:0] PDEO_PM_THR_54 = 4'h2;
    localparam logic [3:0] PDEO_PM_THR_32 = 4'h3;
    localparam logic [3:0] PDEO_PM_THR_10 = 4'h4;
    // port d pin positions
    localparam int PDEO_D_CAPTURE = 0;
    localparam int PDEO_D_EXT_IRQ = 1;
    // port e pin positions
    localparam int PDEO_E_RX = 0;
    localparam int PDEO_E_TX = 1;
    localparam int PDEO_E_XCLK = 2;
    localparam int PDEO_E_CMP_NEG = 3;
    localparam int PDEO_E_SCLK = 4;
    localparam int PDEO_E_SDATA = 5;
    localparam int PDEO_E_SDOUT = 6;
    localparam int PDEO_E_CLKOUT = 7;
    // reset values of the registered pin controls
    localparam logic [7:0] PDEO_RST_PINS = 8'h00;
    localparam logic PDEO_RST_BIT = 1'b0;
endpackage

// >>> verilog/pdeo_pin_resolve.sv
// per-pin override resolution for one port of W pins
// assumes override pairs and port settings are on the system clock
`timescale 1ns/10ps
module pdeo_pin_resolve
    import pdeo_pkg::*;
#(
    parameter int W = PDEO_PORT_W
) (
    input wire logic [W-1:0] latch,
    input wire logic [W-1:0] dir,
    input wire logic pull_disable,
    input wire logic sleep_gate,
    input wire logic [W-1:0] puoe,
    input wire logic [W-1:0] puov,
    input wire logic [W-1:0] ddoe,
    input wire logic [W-1:0] ddov,
    input wire logic [W-1:0] pvoe,
    input wire logic [W-1:0] pvov,
    input wire logic [W-1:0] dieoe,
    input wire logic [W-1:0] dieov,
    output logic [W-1:0] pull_en,
    output logic [W-1:0] drive,
    output logic [W-1:0] value,
    output logic [W-1:0] die
);
    initial begin
        if (W < 1) begin
            $error("pdeo_pin_resolve: W must be at least 1");
        end
    end

    // override value wins when its enable is set
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pull_en[i] = puoe[i] ? puov[i]
                : (latch[i] & ~dir[i] & ~pull_disable);
            drive[i] = ddoe[i] ? ddov[i] : dir[i];
            value[i] = pvoe[i] ? pvov[i] : latch[i];
            die[i] = dieoe[i] ? dieov[i] : ~sleep_gate;
        end
    end
endmodule

// >>> verilog/pdeo_override.sv
// pin override logic for the lcd-shared port d and serial port e
// assumes all controls come from logic on clk; pins are asynchronous
//
// Operation
// - port d pin 0 feeds the 16-bit timer capture trigger input.
// - with the clock-out fuse set, port e pin 7 drives the divided clock.
// - with the fuse set, the divided clock is driven during reset too.
// - direction bit 2 makes the usart external clock output or input.
// - the external clock pin function exists only in synchronous mode.
// - an enabled receiver forces port e pin 0 to input and takes it.
// - the forced receive input gets a pull-up from its latch bit.
// - lcd on and mask count above a pin threshold hands port d pins over.
// - two-wire mode overrides the serial clock pin direction, and its value when its direction bit is set.
// - two-wire mode sets serial data direction from data out and latch.
// - an enabled transmitter forces port e pin 1 out with transmit data.
// - masked pin change pins keep digital input when the group is on.
`timescale 1ns/10ps
module pdeo_override
    import pdeo_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] d_latch,
    input wire logic [7:0] d_dir,
    input wire logic [7:0] e_latch,
    input wire logic [7:0] e_dir,
    input wire logic global_pullup_disable,
    input wire logic input_sleep_gate,
    input wire logic lcd_on,
    input wire logic [PDEO_PM_W-1:0] segment_port_mask_count,
    input wire logic ext_irq_enable,
    input wire logic clock_out_fuse,
    input wire logic divided_sysclk_out,
    input wire logic usart_sync_mode,
    input wire logic usart_ext_clock_out,
    input wire logic transmitter_on,
    input wire logic receiver_on,
    input wire logic transmit_data,
    input wire logic serial_two_wire_mode,
    input wire logic serial_three_wire_mode,
    input wire logic serial_clock_hold,
    input wire logic serial_clock_toggle,
    input wire logic serial_data_out,
    input wire logic start_cond_irq_enable,
    input wire logic comp_pos_input_disable,
    input wire logic comp_neg_input_disable,
    input wire logic pin_change_group_enable,
    input wire logic [7:0] pin_change_mask_bit,
    input wire logic [7:0] d_pin_in,
    input wire logic [7:0] e_pin_in,
    output logic [7:0] d_pin_out,
    output logic [7:0] d_pin_oe,
    output logic [7:0] d_pullup,
    output logic [7:0] d_lcd_segment,
    output logic [7:0] e_pin_out,
    output logic [7:0] e_pin_oe,
    output logic [7:0] e_pullup,
    output logic capture_trigger_in,
    output logic ext_irq_in,
    output logic usart_rx_in,
    output logic usart_ext_clock_in,
    output logic serial_if_data_in,
    output logic serial_if_clock,
    output logic [7:0] pin_change_in
);
    function automatic logic lcd_take(input logic [PDEO_PM_W-1:0] cnt,
                                      input logic [3:0] thr);
        lcd_take = lcd_on & (cnt > thr);
    endfunction

    logic [7:0] d_sync1;
    logic [7:0] d_sync2;
    logic [7:0] e_sync1;
    logic [7:0] e_sync2;
    logic [7:0] lcd_hand;
    logic [7:0] pc_keep;
    logic ext_clk_drive;
    logic scl_toggle;
    logic next_scl_toggle;
    logic [7:0] d_puoe, d_puov, d_ddoe, d_ddov;
    logic [7:0] d_pvoe, d_pvov, d_dieoe, d_dieov;
    logic [7:0] e_puoe, e_puov, e_ddoe, e_ddov;
    logic [7:0] e_pvoe, e_pvov, e_dieoe, e_dieov;
    logic [7:0] d_pu_c, d_oe_c, d_out_c, d_die_c;
    logic [7:0] e_pu_c, e_oe_c, e_out_c, e_die_c;
    logic [7:0] d_die, e_die;
    logic [7:0] e_out_r, e_oe_r;
    logic [7:0] next_d_pin_out, next_d_pin_oe, next_d_pullup;
    logic [7:0] next_d_lcd_segment, next_e_pullup;
    logic [7:0] next_pin_change_in;
    logic next_capture_trigger_in, next_ext_irq_in, next_usart_rx_in;
    logic next_usart_ext_clock_in, next_serial_if_data_in;
    logic next_serial_if_clock;

    // pin synchronisers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            d_sync1 <= PDEO_RST_PINS;
            d_sync2 <= PDEO_RST_PINS;
            e_sync1 <= PDEO_RST_PINS;
            e_sync2 <= PDEO_RST_PINS;
        end else begin
            d_sync1 <= d_pin_in;
            d_sync2 <= d_sync1;
            e_sync1 <= e_pin_in;
            e_sync2 <= e_sync1;
        end
    end

    // override pairs for both ports
    always_comb begin
        lcd_hand[7] = lcd_take(segment_port_mask_count, PDEO_PM_THR_76);
        lcd_hand[6] = lcd_hand[7];
        lcd_hand[5] = lcd_take(segment_port_mask_count, PDEO_PM_THR_54);
        lcd_hand[4] = lcd_hand[5];
        lcd_hand[3] = lcd_take(segment_port_mask_count, PDEO_PM_THR_32);
        lcd_hand[2] = lcd_hand[3];
        lcd_hand[1] = lcd_take(segment_port_mask_count, PDEO_PM_THR_10);
        lcd_hand[0] = lcd_hand[1];
        d_puoe = lcd_hand;
        d_puov = PDEO_RST_PINS;
        d_ddoe = lcd_hand;
        d_ddov = PDEO_RST_PINS;
        d_pvoe = PDEO_RST_PINS;
        d_pvov = PDEO_RST_PINS;
        d_dieoe = lcd_hand;
        d_dieov = PDEO_RST_PINS;
        // external irq keeps its input unless the lcd has the pin
        d_dieoe[PDEO_D_EXT_IRQ] = lcd_hand[PDEO_D_EXT_IRQ] | ext_irq_enable;
        d_dieov[PDEO_D_EXT_IRQ] = ~lcd_hand[PDEO_D_EXT_IRQ] & ext_irq_enable;

        pc_keep = pin_change_mask_bit & {8{pin_change_group_enable}};
        ext_clk_drive = usart_sync_mode & e_dir[PDEO_E_XCLK];
        e_puoe = PDEO_RST_PINS;
        e_puov = PDEO_RST_PINS;
        e_ddoe = PDEO_RST_PINS;
        e_ddov = PDEO_RST_PINS;
        e_pvoe = PDEO_RST_PINS;
        e_pvov = PDEO_RST_PINS;
        e_dieoe = pc_keep;
        e_dieov = pc_keep;
        // receiver: forced input, pull-up from latch
        e_puoe[PDEO_E_RX] = receiver_on;
        e_puov[PDEO_E_RX] = e_latch[PDEO_E_RX] & ~global_pullup_disable;
        e_ddoe[PDEO_E_RX] = receiver_on;
        // transmitter
        e_puoe[PDEO_E_TX] = transmitter_on;
        e_ddoe[PDEO_E_TX] = transmitter_on;
        e_ddov[PDEO_E_TX] = 1'b1;
        e_pvoe[PDEO_E_TX] = transmitter_on;
        e_pvov[PDEO_E_TX] = transmit_data;
        // external clock out in synchronous mode
        e_puoe[PDEO_E_XCLK] = ext_clk_drive;
        e_pvoe[PDEO_E_XCLK] = ext_clk_drive;
        e_pvov[PDEO_E_XCLK] = usart_ext_clock_out;
        // comparator inputs: disable bit turns buffer off unless pin change needs it
        e_dieoe[PDEO_E_XCLK] = pc_keep[PDEO_E_XCLK] | comp_pos_input_disable;
        e_dieoe[PDEO_E_CMP_NEG] = pc_keep[PDEO_E_CMP_NEG]
            | comp_neg_input_disable;
        // two-wire serial clock, toggle flips the held level
        e_ddoe[PDEO_E_SCLK] = serial_two_wire_mode;
        e_ddov[PDEO_E_SCLK] = ((serial_clock_hold | e_latch[PDEO_E_SCLK])
            & e_dir[PDEO_E_SCLK]) ^ scl_toggle;
        e_puoe[PDEO_E_SCLK] = serial_two_wire_mode;
        e_pvoe[PDEO_E_SCLK] = serial_two_wire_mode & e_dir[PDEO_E_SCLK];
        // two-wire serial data
        e_puoe[PDEO_E_SDATA] = serial_two_wire_mode;
        e_ddoe[PDEO_E_SDATA] = serial_two_wire_mode;
        e_ddov[PDEO_E_SDATA] = (serial_data_out | e_latch[PDEO_E_SDATA])
            & e_dir[PDEO_E_SDATA];
        e_pvoe[PDEO_E_SDATA] = serial_two_wire_mode & e_dir[PDEO_E_SDATA];
        // start detector keeps both serial inputs alive
        e_dieoe[PDEO_E_SCLK] = pc_keep[PDEO_E_SCLK] | start_cond_irq_enable;
        e_dieov[PDEO_E_SCLK] = 1'b1;
        e_dieoe[PDEO_E_SDATA] = pc_keep[PDEO_E_SDATA]
            | start_cond_irq_enable;
        e_dieov[PDEO_E_SDATA] = 1'b1;
        // three-wire data output, direction left to its bit
        e_pvoe[PDEO_E_SDOUT] = serial_three_wire_mode;
        e_pvov[PDEO_E_SDOUT] = serial_data_out;
        // clock-out fuse
        e_ddoe[PDEO_E_CLKOUT] = clock_out_fuse;
        e_ddov[PDEO_E_CLKOUT] = 1'b1;
        e_pvoe[PDEO_E_CLKOUT] = clock_out_fuse;
        e_pvov[PDEO_E_CLKOUT] = divided_sysclk_out;
    end

    pdeo_pin_resolve #(.W(PDEO_PORT_W)) u_port_d (
        .latch(d_latch),
        .dir(d_dir),
        .pull_disable(global_pullup_disable),
        .sleep_gate(input_sleep_gate),
        .puoe(d_puoe),
        .puov(d_puov),
        .ddoe(d_ddoe),
        .ddov(d_ddov),
        .pvoe(d_pvoe),
        .pvov(d_pvov),
        .dieoe(d_dieoe),
        .dieov(d_dieov),
        .pull_en(d_pu_c),
        .drive(d_oe_c),
        .value(d_out_c),
        .die(d_die_c)
    );

    pdeo_pin_resolve #(.W(PDEO_PORT_W)) u_port_e (
        .latch(e_latch),
        .dir(e_dir),
        .pull_disable(global_pullup_disable),
        .sleep_gate(input_sleep_gate),
        .puoe(e_puoe),
        .puov(e_puov),
        .ddoe(e_ddoe),
        .ddov(e_ddov),
        .pvoe(e_pvoe),
        .pvov(e_pvov),
        .dieoe(e_dieoe),
        .dieov(e_dieov),
        .pull_en(e_pu_c),
        .drive(e_oe_c),
        .value(e_out_c),
        .die(e_die_c)
    );

    // next register values
    always_comb begin
        next_d_pin_out = d_out_c;
        next_d_pin_oe = d_oe_c;
        next_d_pullup = d_pu_c;
        next_d_lcd_segment = lcd_hand;
        next_e_pullup = e_pu_c;
        next_scl_toggle = serial_two_wire_mode
            & (scl_toggle ^ serial_clock_toggle);
        next_capture_trigger_in = d_sync2[PDEO_D_CAPTURE]
            & d_die[PDEO_D_CAPTURE];
        next_ext_irq_in = d_sync2[PDEO_D_EXT_IRQ] & d_die[PDEO_D_EXT_IRQ];
        next_usart_rx_in = receiver_on & e_sync2[PDEO_E_RX]
            & e_die[PDEO_E_RX];
        next_usart_ext_clock_in = usart_sync_mode & ~e_dir[PDEO_E_XCLK]
            & e_sync2[PDEO_E_XCLK] & e_die[PDEO_E_XCLK];
        next_serial_if_data_in = e_sync2[PDEO_E_SDATA]
            & e_die[PDEO_E_SDATA];
        next_serial_if_clock = e_sync2[PDEO_E_SCLK] & e_die[PDEO_E_SCLK];
        next_pin_change_in = e_sync2 & e_die;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            d_pin_out <= PDEO_RST_PINS;
            d_pin_oe <= PDEO_RST_PINS;
            d_pullup <= PDEO_RST_PINS;
            d_lcd_segment <= PDEO_RST_PINS;
            d_die <= PDEO_RST_PINS;
            e_out_r <= PDEO_RST_PINS;
            e_oe_r <= PDEO_RST_PINS;
            e_pullup <= PDEO_RST_PINS;
            e_die <= PDEO_RST_PINS;
            scl_toggle <= PDEO_RST_BIT;
            capture_trigger_in <= PDEO_RST_BIT;
            ext_irq_in <= PDEO_RST_BIT;
            usart_rx_in <= PDEO_RST_BIT;
            usart_ext_clock_in <= PDEO_RST_BIT;
            serial_if_data_in <= PDEO_RST_BIT;
            serial_if_clock <= PDEO_RST_BIT;
            pin_change_in <= PDEO_RST_PINS;
        end else begin
            d_pin_out <= next_d_pin_out;
            d_pin_oe <= next_d_pin_oe;
            d_pullup <= next_d_pullup;
            d_lcd_segment <= next_d_lcd_segment;
            d_die <= d_die_c;
            e_out_r <= e_out_c;
            e_oe_r <= e_oe_c;
            e_pullup <= next_e_pullup;
            e_die <= e_die_c;
            scl_toggle <= next_scl_toggle;
            capture_trigger_in <= next_capture_trigger_in;
            ext_irq_in <= next_ext_irq_in;
            usart_rx_in <= next_usart_rx_in;
            usart_ext_clock_in <= next_usart_ext_clock_in;
            serial_if_data_in <= next_serial_if_data_in;
            serial_if_clock <= next_serial_if_clock;
            pin_change_in <= next_pin_change_in;
        end
    end

    // clock-out pin bypasses the flops so it runs in reset
    always_comb begin
        e_pin_out = e_out_r;
        e_pin_oe = e_oe_r;
        e_pin_out[PDEO_E_CLKOUT] = clock_out_fuse ? divided_sysclk_out
            : e_out_r[PDEO_E_CLKOUT];
        e_pin_oe[PDEO_E_CLKOUT] = clock_out_fuse | e_oe_r[PDEO_E_CLKOUT];
    end
endmodule

// >>> testbench/pdeo_override_chk.sv
// assertion checker for the port d/e override pin controls
// assumes binding onto pdeo_override, one clock domain
`timescale 1ns/10ps
module pdeo_override_chk
    import pdeo_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] e_latch,
    input wire logic [7:0] e_dir,
    input wire logic global_pullup_disable,
    input wire logic lcd_on,
    input wire logic [PDEO_PM_W-1:0] segment_port_mask_count,
    input wire logic clock_out_fuse,
    input wire logic divided_sysclk_out,
    input wire logic usart_sync_mode,
    input wire logic transmitter_on,
    input wire logic receiver_on,
    input wire logic transmit_data,
    input wire logic serial_two_wire_mode,
    input wire logic serial_three_wire_mode,
    input wire logic serial_data_out,
    input wire logic [7:0] d_pin_oe,
    input wire logic [7:0] d_pullup,
    input wire logic [7:0] d_lcd_segment,
    input wire logic [7:0] e_pin_out,
    input wire logic [7:0] e_pin_oe,
    input wire logic [7:0] e_pullup,
    input wire logic usart_ext_clock_in
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_clkout_fuse_pass: assert property (
        clock_out_fuse |-> e_pin_oe[7] && e_pin_out[7] == divided_sysclk_out)
        else $error("clock out pin not driven from divided clock");
    a_rx_forced_in: assert property (
        receiver_on |=> e_pin_oe[0] == 1'b0)
        else $error("receive pin still driven");
    a_rx_pullup_on: assert property (
        receiver_on && e_latch[0] && !global_pullup_disable |=> e_pullup[0])
        else $error("receive pin pull-up missing");
    a_tx_forced_out: assert property (
        transmitter_on |=> e_pin_oe[1] && !e_pullup[1]
        && e_pin_out[1] == $past(transmit_data))
        else $error("transmit pin wrong");
    a_lcd_full_mask: assert property (
        lcd_on && segment_port_mask_count > 4'h4 |=> d_lcd_segment == 8'hff
        && d_pin_oe == 8'h00 && d_pullup == 8'h00)
        else $error("lcd pins not all handed over");
    a_lcd_off_free: assert property (
        !lcd_on |=> d_lcd_segment == 8'h00)
        else $error("lcd holds pins while off");
    a_two_wire_data: assert property (
        serial_two_wire_mode && e_dir[5] |=> e_pin_out[5] == 1'b0
        && !e_pullup[5]
        && e_pin_oe[5] == ($past(serial_data_out) | $past(e_latch[5])))
        else $error("serial data pin wrong in two-wire mode");
    a_two_wire_clk: assert property (
        serial_two_wire_mode && e_dir[4] |=> e_pin_out[4] == 1'b0
        && !e_pullup[4])
        else $error("serial clock pin wrong in two-wire mode");
    a_three_wire_out: assert property (
        serial_three_wire_mode |=> e_pin_out[6] == $past(serial_data_out)
        && e_pin_oe[6] == $past(e_dir[6]))
        else $error("data output pin wrong in three-wire mode");
    a_extclk_async_idle: assert property (
        !usart_sync_mode [*3] |=> usart_ext_clock_in == 1'b0)
        else $error("external clock input active outside sync mode");
endmodule

bind pdeo_override pdeo_override_chk i_pdeo_override_chk (.*);

// >>> testbench/pdeo_pin_far.sv
// far side of one port: pin levels from drivers, pull-ups, outside
// assumes pin controls come from pdeo_override on the same clock
`timescale 1ns/10ps
module pdeo_pin_far (
    input wire logic clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_en,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_in
);
    logic flip = 1'b0;
    // floating pins show a changing pattern, never a stale value
    always @(posedge clk) flip <= ~flip;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pull_en | (8'h55 ^ {8{flip}})));
endmodule

// >>> testbench/pdeo_override_test.sv
// self-checking bench for the port d/e override block
// assumes pdeo_override, pdeo_pin_far and the bound checker
`timescale 1ns/10ps
module pdeo_override_test;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] d_latch, d_dir, e_latch, e_dir, pin_change_mask_bit;
    logic [3:0] segment_port_mask_count;
    logic global_pullup_disable, input_sleep_gate, lcd_on, ext_irq_enable;
    logic clock_out_fuse, divided_sysclk_out, usart_sync_mode;
    logic usart_ext_clock_out, transmitter_on, receiver_on, transmit_data;
    logic serial_two_wire_mode, serial_three_wire_mode, serial_clock_hold;
    logic serial_clock_toggle, serial_data_out, start_cond_irq_enable;
    logic comp_pos_input_disable, comp_neg_input_disable;
    logic pin_change_group_enable;
    logic [7:0] d_pin_in, e_pin_in, d_pin_out, d_pin_oe, d_pullup;
    logic [7:0] d_lcd_segment, e_pin_out, e_pin_oe, e_pullup, pin_change_in;
    logic capture_trigger_in, ext_irq_in, usart_rx_in, usart_ext_clock_in;
    logic serial_if_data_in, serial_if_clock;
    logic [7:0] d_ext, d_ext_en, e_ext, e_ext_en;
    logic [7:0] want, got;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;

    pdeo_override i_pdeo_override (.*);
    pdeo_pin_far i_pdeo_pin_far_d (.clk(clk), .pin_out(d_pin_out),
        .pin_oe(d_pin_oe), .pull_en(d_pullup), .ext_val(d_ext),
        .ext_en(d_ext_en), .pin_in(d_pin_in));
    pdeo_pin_far i_pdeo_pin_far_e (.clk(clk), .pin_out(e_pin_out),
        .pin_oe(e_pin_oe), .pull_en(e_pullup), .ext_val(e_ext),
        .ext_en(e_ext_en), .pin_in(e_pin_in));

    always #10 clk = ~clk;

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // toggle pulses only allowed in two-wire mode
    task automatic drive(input logic [31:0] r, input logic [75:0] v);
        {global_pullup_disable, input_sleep_gate, lcd_on, ext_irq_enable,
         clock_out_fuse, divided_sysclk_out, usart_sync_mode,
         usart_ext_clock_out, transmitter_on, receiver_on, transmit_data,
         serial_three_wire_mode, serial_clock_hold, serial_data_out,
         start_cond_irq_enable, comp_pos_input_disable,
         comp_neg_input_disable, pin_change_group_enable,
         serial_two_wire_mode} <= r[18:0];
        serial_clock_toggle <= r[19] & r[0];
        {d_latch, d_dir, e_latch, e_dir, pin_change_mask_bit,
         segment_port_mask_count, d_ext, d_ext_en, e_ext, e_ext_en} <= v;
    endtask

    task automatic tick();
        repeat (2) @(posedge clk);
        #1;
    endtask

    function automatic logic [7:0] lcd_exp(input logic [3:0] c);
        return {{2{c > 4'h1}}, {2{c > 4'h2}}, {2{c > 4'h3}}, {2{c > 4'h4}}};
    endfunction

    // port e digital input enables with all pins otherwise idle
    function automatic logic [7:0] die_exp();
        logic [7:0] keep;
        logic [7:0] e;
        keep = pin_change_mask_bit & {8{pin_change_group_enable}};
        e = keep | {8{~input_sleep_gate}};
        e[2] = comp_pos_input_disable ? keep[2] : e[2];
        e[3] = comp_neg_input_disable ? keep[3] : e[3];
        e[5:4] = start_cond_irq_enable ? 2'b11 : e[5:4];
        return e;
    endfunction

    initial begin
        void'($urandom(95242));
        drive(32'h0, 76'h0);
        repeat (4) begin
            @(posedge clk);
            clock_out_fuse <= 1'b1;
            divided_sysclk_out <= ~divided_sysclk_out;
            #1;
            chk({7'h00, e_pin_oe[7]}, 8'h01);
            chk({7'h00, e_pin_out[7]}, {7'h00, divided_sysclk_out});
            chk(d_pin_oe, 8'h00);
        end
        @(posedge clk);
        arst_n <= 1'b1;
        drive(32'h0, 76'h0);
        repeat (40) begin
            @(posedge clk);
            d_latch <= 8'($urandom);
            d_dir <= 8'($urandom);
            global_pullup_disable <= 1'($urandom);
            tick();
            chk(d_pin_oe, d_dir);
            chk(d_pin_out, d_latch);
            want = d_latch & ~d_dir & {8{~global_pullup_disable}};
            chk(d_pullup, want);
        end
        for (int c = 0; c < 16; c++) begin
            @(posedge clk);
            lcd_on <= 1'b1;
            d_latch <= 8'hff;
            d_dir <= 8'h0f;
            global_pullup_disable <= 1'b0;
            segment_port_mask_count <= 4'(c);
            tick();
            chk(d_lcd_segment, lcd_exp(4'(c)));
            chk(d_pin_oe, ~lcd_exp(4'(c)) & 8'h0f);
            chk(d_pullup, ~lcd_exp(4'(c)) & 8'hf0);
        end
        @(posedge clk);
        drive(32'h0, 76'h0);
        @(posedge clk);
        receiver_on <= 1'b1;
        e_latch <= 8'h01;
        e_dir <= 8'h01;
        e_ext_en <= 8'h01;
        d_ext_en <= 8'h01;
        for (int b = 0; b < 2; b++) begin
            @(posedge clk);
            e_ext <= 8'(b);
            d_ext <= 8'(b);
            tick();
            chk({7'h00, e_pin_oe[0]}, 8'h00);
            chk({7'h00, e_pullup[0]}, 8'h01);
            repeat (3) @(posedge clk);
            chk({7'h00, usart_rx_in}, 8'(b));
            chk({7'h00, capture_trigger_in}, 8'(b));
        end
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            usart_sync_mode <= 1'(s);
            usart_ext_clock_out <= 1'b1;
            e_dir <= 8'h04;
            e_latch <= 8'h00;
            tick();
            chk({7'h00, e_pin_out[2]}, 8'(s));
            chk({7'h00, e_pin_oe[2]}, 8'h01);
        end
        // all pins idle inputs held high from outside
        @(posedge clk);
        drive(32'h0, 76'hffff_ffff);
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            pin_change_mask_bit <= 8'($urandom);
            {pin_change_group_enable, input_sleep_gate, ext_irq_enable,
             start_cond_irq_enable, comp_pos_input_disable,
             comp_neg_input_disable} <= 6'($urandom);
            repeat (4) @(posedge clk);
            #1;
            want = die_exp();
            chk(pin_change_in, want);
            chk({6'h00, pin_change_in[3:2]}, {6'h00, want[3:2]});
            got = {6'h00, serial_if_data_in, serial_if_clock};
            chk(got, {6'h00, want[5:4]});
            got = {7'h00, ext_irq_in};
            chk(got, {7'h00, ext_irq_enable | ~input_sleep_gate});
        end
        repeat (400) begin
            @(posedge clk);
            drive($urandom, 76'({$urandom, $urandom, $urandom}));
            @(posedge clk);
            #1;
            want = lcd_on ? lcd_exp(segment_port_mask_count) : 8'h00;
            chk(d_lcd_segment, want);
        end
        give_verdict();
    end
endmodule
